// ---- src/bvc_regs.sv ----
// buck voltage code registers behind a serial two-wire slave
`timescale 1ns/1ns

module bvc_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic [6:0] buck1_code,
  output logic [6:0] buck2_code,
  output logic [11:0] buck1_target_mv,
  output logic [11:0] buck2_target_mv,
  output logic link_busy
);

  // link clock domain
  // each rising scl samples the data line; the toggle tells the core a bit
  // is waiting, and the bit holds still until the next rising scl, which is
  // far longer than the crossing takes
  logic link_bit_r;
  logic link_tgl_r;

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      link_bit_r <= 1'b1;
      link_tgl_r <= 1'b0;
    end else begin
      link_bit_r <= sda_i;
      link_tgl_r <= ~link_tgl_r;
    end
  end

  // crossing into the core clock
  logic [2:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic tgl_s;

  bvc_sync #(
    .WIDTH(3),
    .RST(3'h3)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({link_tgl_r, sda_i, scl}),
    .q(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign tgl_s = sync_q[2];

  logic scl_d_r;
  logic sda_d_r;
  logic tgl_d_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tgl_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tgl_d_r <= tgl_s;
    end
  end

  logic rise_evt;
  logic fall_evt;
  logic start_evt;
  logic stop_evt;

  // start and stop are data edges while the clock line is high
  assign rise_evt = tgl_s ^ tgl_d_r;
  assign fall_evt = scl_d_r & ~scl_s;
  assign start_evt = scl_s & sda_d_r & ~sda_s;
  assign stop_evt = scl_s & ~sda_d_r & sda_s;

  // register storage
  localparam int NUM_BUCK = bvc_pkg::NUM_BUCK;
  logic [6:0] code_r [NUM_BUCK];
  logic [11:0] mv_r [NUM_BUCK];
  logic [7:0] ptr_r;
  logic [7:0] sh_r;
  logic wr_stb;

  for (genvar ch = 0; ch < NUM_BUCK; ch++) begin : g_ch
    logic [6:0] eff_code;

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        code_r[ch] <= bvc_pkg::CODE_RESET;
      end else if (wr_stb && ptr_r == bvc_pkg::REG_BUCK1_OFS + 8'(ch)) begin
        // the reserved top bit of the written byte is dropped here
        code_r[ch] <= sh_r[6:0];
      end
    end

    // out-of-range codes are held at the top step rather than overshooting
    assign eff_code = (code_r[ch] > bvc_pkg::CODE_MAX) ? bvc_pkg::CODE_MAX : code_r[ch];

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        mv_r[ch] <= bvc_pkg::MV_BASE + bvc_pkg::MV_STEP * {5'h00, bvc_pkg::CODE_RESET};
      end else begin
        mv_r[ch] <= bvc_pkg::MV_BASE + bvc_pkg::MV_STEP * {5'h00, eff_code};
      end
    end
  end

  assign buck1_code = code_r[0];
  assign buck2_code = code_r[1];
  assign buck1_target_mv = mv_r[0];
  assign buck2_target_mv = mv_r[1];

  // read view: unmapped offsets read as zero
  function automatic logic [7:0] rd_sel(
    input logic [7:0] p,
    input logic [6:0] c0,
    input logic [6:0] c1
  );
    logic [7:0] v;
    v = 8'h00;
    if (p == bvc_pkg::REG_BUCK1_OFS) begin
      v = {1'b0, c0};
    end else if (p == bvc_pkg::REG_BUCK2_OFS) begin
      v = {1'b0, c1};
    end
    return v;
  endfunction

  logic [7:0] rd_cur;
  logic [7:0] rd_next;
  logic [7:0] ptr_inc;

  assign ptr_inc = ptr_r + 8'h01;
  assign rd_cur = rd_sel(ptr_r, code_r[0], code_r[1]);
  assign rd_next = rd_sel(ptr_inc, code_r[0], code_r[1]);

  // frame sequencer
  bvc_pkg::bvc_state_t state_r;
  bvc_pkg::bvc_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic rw_r;
  logic rw_nxt;
  logic mack_r;
  logic mack_nxt;
  logic sda_oe_n_r;
  logic sda_oe_n_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    sda_oe_n_nxt = sda_oe_n_r;
    wr_stb = 1'b0;
    if (stop_evt) begin
      state_nxt = bvc_pkg::ST_IDLE;
      sda_oe_n_nxt = 1'b1;
    end else if (start_evt) begin
      // a repeated start keeps the pointer, so a read may follow a pointer write
      state_nxt = bvc_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_n_nxt = 1'b1;
    end else if (state_r != bvc_pkg::ST_IDLE) begin
      if (rise_evt) begin
        if (cnt_r < bvc_pkg::BIT_ACK) begin
          sh_nxt = {sh_r[6:0], link_bit_r};
        end else if (cnt_r == bvc_pkg::BIT_ACK) begin
          mack_nxt = ~link_bit_r;
        end
        if (cnt_r != bvc_pkg::BIT_END) begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end else if (fall_evt) begin
        if (cnt_r == bvc_pkg::BIT_ACK) begin
          case (state_r)
            bvc_pkg::ST_ADDR: begin
              if (sh_r[7:1] == bvc_pkg::SLAVE_ADDR) begin
                sda_oe_n_nxt = 1'b0;
                rw_nxt = sh_r[0];
              end else begin
                state_nxt = bvc_pkg::ST_IDLE;
              end
            end
            bvc_pkg::ST_PTR: begin
              sda_oe_n_nxt = 1'b0;
              ptr_nxt = sh_r;
            end
            bvc_pkg::ST_WDATA: begin
              sda_oe_n_nxt = 1'b0;
              wr_stb = 1'b1;
              ptr_nxt = ptr_inc;
            end
            bvc_pkg::ST_RDATA: begin
              sda_oe_n_nxt = 1'b1;
            end
            default: begin
              sda_oe_n_nxt = 1'b1;
            end
          endcase
        end else if (cnt_r == bvc_pkg::BIT_END) begin
          cnt_nxt = 4'h0;
          case (state_r)
            bvc_pkg::ST_ADDR: begin
              if (rw_r) begin
                state_nxt = bvc_pkg::ST_RDATA;
                tx_nxt = rd_cur;
                sda_oe_n_nxt = rd_cur[bvc_pkg::BIT_MSB];
              end else begin
                state_nxt = bvc_pkg::ST_PTR;
                sda_oe_n_nxt = 1'b1;
              end
            end
            bvc_pkg::ST_PTR: begin
              state_nxt = bvc_pkg::ST_WDATA;
              sda_oe_n_nxt = 1'b1;
            end
            bvc_pkg::ST_WDATA: begin
              sda_oe_n_nxt = 1'b1;
            end
            bvc_pkg::ST_RDATA: begin
              ptr_nxt = ptr_inc;
              if (mack_r) begin
                tx_nxt = rd_next;
                sda_oe_n_nxt = rd_next[bvc_pkg::BIT_MSB];
              end else begin
                state_nxt = bvc_pkg::ST_IDLE;
                sda_oe_n_nxt = 1'b1;
              end
            end
            default: begin
              sda_oe_n_nxt = 1'b1;
            end
          endcase
        end else if (state_r == bvc_pkg::ST_RDATA) begin
          // open drain: a one is sent by releasing the line
          sda_oe_n_nxt = tx_r[bvc_pkg::BIT_MSB - cnt_r[2:0]];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= bvc_pkg::ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 8'h00;
      tx_r <= 8'h00;
    end else begin
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= 8'h00;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else begin
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe_n_r <= 1'b1;
    end else begin
      sda_oe_n_r <= sda_oe_n_nxt;
    end
  end

  // no clock stretching: the block keeps up with a 400 kb/s host easily
  logic busy_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != bvc_pkg::ST_IDLE);
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign link_busy = busy_r;

endmodule

// ---- common/bvc_pkg.sv ----
// shared constants and types for the buck voltage code register block
package bvc_pkg;

  // register offsets on the serial link
  localparam logic [7:0] REG_BUCK1_OFS = 8'h00;
  localparam logic [7:0] REG_BUCK2_OFS = 8'h01;

  // register layout: one reserved top bit, seven code bits below it
  localparam int NUM_BUCK = 2;
  localparam int CODE_W = 7;
  localparam int REG_W = 8;
  localparam int RSVD_BIT = 7;
  localparam logic [6:0] CODE_RESET = 7'h10;
  localparam logic [6:0] CODE_MAX = 7'h6F;

  // voltage decode in millivolts: 825 base, 25 per step, 3600 at the top
  localparam int MV_W = 12;
  localparam logic [11:0] MV_BASE = 12'h339;
  localparam logic [11:0] MV_STEP = 12'h019;
  localparam logic [11:0] MV_MAX = 12'hE10;

  // serial link
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam int LINK_MAX_KBPS = 400;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [2:0] BIT_MSB = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA
  } bvc_state_t;

endpackage

// ---- src/bvc_sync.sv ----
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module bvc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_r[i] <= RST[i];
        sync_r[i] <= RST[i];
      end else begin
        meta_r[i] <= d[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign q = sync_r;

endmodule

// ---- dv/bvc_regs_assertions.sv ----
// port-level checks for the voltage code register block
`timescale 1ns/1ns
module bvc_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic [6:0] buck1_code,
  input wire logic [6:0] buck2_code,
  input wire logic [11:0] buck1_target_mv,
  input wire logic [11:0] buck2_target_mv,
  input wire logic link_busy
);
  logic seen_r;
  function automatic logic [11:0] mv(input logic [6:0] c);
    return bvc_pkg::MV_BASE + bvc_pkg::MV_STEP * ((c > bvc_pkg::CODE_MAX) ? 12'h06F : {5'h00, c});
  endfunction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) seen_r <= 1'b0;
    else seen_r <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RST_VAL: assert property (
    !seen_r |-> buck1_code == 7'h10 && buck2_code == 7'h10 && sda_oe_n && !link_busy)
    else $error("bad value after reset");
  AST_MV1: assert property (1'b1 |=> buck1_target_mv == mv($past(buck1_code)))
    else $error("buck1 target wrong");
  AST_MV2: assert property (1'b1 |=> buck2_target_mv == mv($past(buck2_code)))
    else $error("buck2 target wrong");
  AST_MV_CAP: assert property (buck1_target_mv <= 12'hE10 && buck2_target_mv <= 12'hE10)
    else $error("target above top");
  AST_CODE_HOLD: assert property (
    !link_busy && !$past(link_busy) |-> $stable(buck1_code) && $stable(buck2_code))
    else $error("code moved while idle");
  AST_SDA_O: assert property (sda_o == 1'b0)
    else $error("data value not zero");
  AST_OE_IDLE: assert property (!link_busy && !$past(link_busy) |-> sda_oe_n)
    else $error("line pulled while idle");
  AST_OE_HOLD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("pull too short");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data changed with clock high");
  AST_BUSY_START: assert property ($rose(link_busy) |-> scl)
    else $error("busy without start");
endmodule

// ---- dv/bvc_host.sv ----
// two-wire host model; line edges sit 3 ns off the core clock grid
`timescale 1ns/1ns
module bvc_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_h
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // long high after the fall so the synchronised start is seen first
  task automatic start();
    @(posedge clk);
    #3 sda_h = 1'b1;
    #40 scl = 1'b1;
    #80 sda_h = 1'b0;
    #80 scl = 1'b0;
  endtask
  // bit time scaled down from the rate limit to keep runs short; each phase still spans 4 core clocks
  task automatic bit_io(input logic b, output logic r);
    #40 sda_h = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(last, ack);
  endtask
  task automatic stop();
    #40 sda_h = 1'b0;
    #40 scl = 1'b1;
    #80 sda_h = 1'b1;
    #80;
  endtask
endmodule

// ---- dv/tb_buck_voltage_code_registers.sv ----
// self-checking bench for the voltage code register block
`timescale 1ns/1ns
module tb_buck_voltage_code_registers;
  logic clk;
  logic rstn;
  logic scl;
  logic sda_h;
  logic sda_o;
  logic sda_oe_n;
  logic link_busy;
  logic [6:0] buck1_code;
  logic [6:0] buck2_code;
  logic [11:0] buck1_target_mv;
  logic [11:0] buck2_target_mv;
  logic [7:0] rd;
  logic ak;
  int error_cnt = 0;
  int checks_done = 0;
  // pull-up on the line
  wire logic sda = sda_h & (sda_oe_n | sda_o);
  bvc_regs u_dut (.clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .buck1_code(buck1_code), .buck2_code(buck2_code), .buck1_target_mv(buck1_target_mv),
    .buck2_target_mv(buck2_target_mv), .link_busy(link_busy));
  bvc_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t mv got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] mv(input logic [6:0] c);
    return bvc_pkg::MV_BASE + bvc_pkg::MV_STEP * ((c > bvc_pkg::CODE_MAX) ? 12'h06F : {5'h00, c});
  endfunction
  task automatic wr(input logic [7:0] b);
    u_host.xfer(b, 1'b1, rd, ak);
    chk8({7'h00, ak}, 8'h00);
  endtask
  task automatic rdb(input logic last, input logic [7:0] exp);
    u_host.xfer(8'hFF, last, rd, ak);
    chk8(rd, exp);
  endtask
  task automatic codes(input logic [6:0] c1, input logic [6:0] c2);
    repeat (3) @(posedge clk);
    #1;
    chk8({1'b0, buck1_code}, {1'b0, c1});
    chk8({1'b0, buck2_code}, {1'b0, c2});
    chk12(buck1_target_mv, mv(c1));
    chk12(buck2_target_mv, mv(c2));
  endtask
  task automatic t_burst();
    u_host.start();
    wr(8'hD0);
    wr(8'h00);
    wr(8'h25);
    wr(8'h6F);
    u_host.stop();
    codes(7'h25, 7'h6F);
    u_host.start();
    wr(8'hD0);
    wr(8'h00);
    u_host.start();
    wr(8'hD1);
    rdb(1'b0, 8'h25);
    rdb(1'b1, 8'h6F);
    u_host.stop();
  endtask
  // top bit written high must read back low; pointer left at 1
  task automatic t_rsvd();
    u_host.start();
    wr(8'hD0);
    wr(8'h00);
    wr(8'hFF);
    u_host.stop();
    codes(7'h7F, 7'h6F);
    u_host.start();
    wr(8'hD1);
    rdb(1'b0, 8'h6F);
    rdb(1'b1, 8'h00);
    u_host.stop();
    u_host.start();
    wr(8'hD0);
    wr(8'h00);
    u_host.start();
    wr(8'hD1);
    rdb(1'b1, 8'h7F);
    u_host.stop();
  endtask
  task automatic t_refuse();
    u_host.start();
    u_host.xfer(8'hD2, 1'b1, rd, ak);
    chk8({7'h00, ak}, 8'h01);
    u_host.xfer(8'h00, 1'b1, rd, ak);
    u_host.stop();
    u_host.start();
    wr(8'hD0);
    wr(8'h02);
    wr(8'h33);
    u_host.start();
    wr(8'hD1);
    rdb(1'b1, 8'h00);
    u_host.stop();
    codes(7'h7F, 7'h6F);
  endtask
  task automatic t_rerst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    codes(7'h10, 7'h10);
    chk8({7'h00, sda_oe_n}, 8'h01);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    codes(7'h10, 7'h10);
    t_burst();
    t_rsvd();
    t_refuse();
    t_rerst();
    final_report();
  end
  // traffic needs well under 100 us
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
endmodule
bind bvc_regs bvc_chk u_chk (.clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .buck1_code(buck1_code), .buck2_code(buck2_code), .buck1_target_mv(buck1_target_mv),
  .buck2_target_mv(buck2_target_mv), .link_busy(link_busy));
